// [inc/bsld_regs.svh]
// Offsets, flag positions, reset values and cycle counts of the bit/shift/load datapath.
// Assumes inclusion by bare name from the package and the checker module.
`ifndef BSLD_REGS_SVH
`define BSLD_REGS_SVH

// Software port map: 32 working registers, then the processor flags register
`define BSLD_SW_AW        6
`define BSLD_NUM_WREGS    32
`define BSLD_OFS_FLAGS    6'h3F

// Processor flags register bit positions
`define BSLD_FLAG_C       0
`define BSLD_FLAG_Z       1
`define BSLD_FLAG_N       2
`define BSLD_FLAG_V       3
`define BSLD_FLAG_S       4
`define BSLD_FLAG_H       5
`define BSLD_FLAG_T       6
`define BSLD_FLAG_I       7

// Reset values
`define BSLD_FLAGS_RST    8'h00
`define BSLD_WREG_RST     8'h00

// Low byte index of each data pointer pair
`define BSLD_PTR_X_LO     5'h1A
`define BSLD_PTR_Y_LO     5'h1C
`define BSLD_PTR_Z_LO     5'h1E

// Execution length in clock cycles
`define BSLD_CYC_SHORT    1
`define BSLD_CYC_LONG     2

`endif

// [inc/bsld_pkg.sv]
// Types shared by the datapath and its surroundings.
// Assumes bsld_regs.svh sits on the include path.
package bsld_pkg;
    `include "bsld_regs.svh"

    // Operations carried out by this slice
    typedef enum logic [4:0] {
        IO_BIT_SET_OP,
        IO_BIT_CLEAR_OP,
        LOGICAL_LEFT_SHIFT_OP,
        LOGICAL_RIGHT_SHIFT_OP,
        ROTATE_LEFT_CARRY_OP,
        ROTATE_RIGHT_CARRY_OP,
        ARITH_RIGHT_SHIFT_OP,
        BIT_TO_TRANSFER_FLAG_OP,
        TRANSFER_FLAG_TO_BIT_OP,
        SIGNED_FLAG_SET_OP,
        SIGNED_FLAG_CLEAR_OP,
        OVERFLOW_FLAG_SET_OP,
        OVERFLOW_FLAG_CLEAR_OP,
        HALF_CARRY_SET_OP,
        HALF_CARRY_CLEAR_OP,
        INDIRECT_LOAD_OP,
        DISPLACED_LOAD_OP
    } bsld_op_t;

    // Data pointer selection
    typedef enum logic [1:0] {
        PTR_X,
        PTR_Y,
        PTR_Z
    } bsld_ptr_t;

    // Addressing of an indirect load
    typedef enum logic [1:0] {
        ADDR_PLAIN,
        ADDR_POST_INC,
        ADDR_PRE_DEC
    } bsld_mode_t;

    // Sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } bsld_state_t;

    // One decoded instruction as handed over by the decoder
    typedef struct packed {
        bsld_op_t   op;
        logic [4:0] dst_idx;
        logic [4:0] src_idx;
        logic [2:0] bit_sel;
        logic [4:0] io_addr;
        bsld_ptr_t  ptr;
        bsld_mode_t mode;
        logic [5:0] disp;
    } bsld_cmd_t;
endpackage

// [logic/bsld_datapath.sv]
// Bit, shift, flag and indirect-load execution slice of an 8-bit core, with its working registers
// and processor flags register. Assumes a decoder that holds each command for one cycle,
// an I/O space and a data memory that both return read data in the same cycle as the read strobe.
// What this block does
// - Setting an I/O bit forces that one bit of the I/O register to one in two cycles, flags untouched.
// - Clearing an I/O bit forces that one bit of the I/O register to zero in two cycles, flags untouched.
// - A logical left shift moves bits up, puts zero in bit 0 and updates Z, C, N and V in one cycle.
// - A logical right shift moves bits down, puts zero in bit 7 and updates Z, C, N and V in one cycle.
// - Rotate left puts old carry in bit 0 and old bit 7 in carry, updating Z, N and V, in one cycle.
// - Rotate right puts old carry in bit 7 and old bit 0 in carry, updating Z, N and V, in one cycle.
// - An arithmetic right shift moves bits down while bit 7 stays and updates Z, C, N and V in one cycle.
// - A bit store copies one source bit into the transfer flag and changes nothing else, in one cycle.
// - A bit load copies the transfer flag into one destination bit, flags unchanged, in one cycle.
// - Single-cycle operations set or clear the signed-test flag alone.
// - Single-cycle operations set or clear the overflow flag alone.
// - Single-cycle operations set or clear the half-carry flag alone.
// - A post-increment load reads memory at the pointer, then adds one to it, in two cycles, flags kept.
// - A pre-decrement load subtracts one from the pointer, then reads there, in two cycles, flags kept.
// - A displaced load reads at the Y or Z pointer plus displacement, pointer kept, in two cycles.
`timescale 1ns/10ps

module bsld_datapath
    import bsld_pkg::*;
#(
    parameter int DM_AW = 16,
    parameter int IO_AW = 5
)
(
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     cmd_valid,
    input  wire bsld_cmd_t                cmd,
    output logic                          cmd_busy_r,
    output logic                          cmd_done_r,
    output logic [IO_AW-1:0]              io_addr_r,
    output logic                          io_rd_r,
    output logic                          io_wr_r,
    output logic [7:0]                    io_wdata_r,
    input  wire logic [7:0]               io_rdata,
    output logic [DM_AW-1:0]              dm_addr_r,
    output logic                          dm_rd_r,
    input  wire logic [7:0]               dm_rdata,
    input  wire logic [`BSLD_SW_AW-1:0]   sw_addr,
    input  wire logic [7:0]               sw_wdata,
    input  wire logic                     sw_wr,
    input  wire logic                     sw_rd,
    output logic [7:0]                    sw_rdata_r,
    output logic [7:0]                    flags_r
);

    // Pointers are register pairs; the address width must match them
    generate
        if (DM_AW != 16)
        begin : g_chk_dm
            $error("bsld_datapath: DM_AW must be 16");
        end
        // The command carries a 5-bit I/O address, so a wider port has nothing to fill it
        if (IO_AW < 1 || IO_AW > 5)
        begin : g_chk_io
            $error("bsld_datapath: IO_AW must be 1 to 5");
        end
    endgenerate

    logic [7:0]   wreg_r [`BSLD_NUM_WREGS];
    bsld_state_t  state_r;
    logic         pend_io_r;
    logic         pend_set_r;
    logic [2:0]   pend_bit_r;
    logic [4:0]   pend_dst_r;

    logic         accept;
    logic [7:0]   dst_val;
    logic [7:0]   src_val;
    logic [7:0]   res;
    logic         res_wr;
    logic [7:0]   flags_nxt;
    logic         flags_wr;
    logic         long_op;
    logic         refused;
    logic [4:0]   ptr_lo;
    logic [15:0]  ptr_val;
    logic [15:0]  ptr_nxt;
    logic         ptr_wr;
    logic [15:0]  ld_addr;
    logic [7:0]   bit_mask;
    logic [7:0]   io_bit_mask;

    // Commands are taken only while idle; a second one during a load or I/O access is dropped
    assign accept  = cmd_valid && (state_r == ST_IDLE);
    assign dst_val = wreg_r[cmd.dst_idx];
    assign src_val = wreg_r[cmd.src_idx];
    assign bit_mask = 8'h01 << cmd.bit_sel;
    assign io_bit_mask = 8'h01 << pend_bit_r;

    // Pointer pair selection and the load address
    always_comb
    begin
        case (cmd.ptr)
            PTR_X:   ptr_lo = `BSLD_PTR_X_LO;
            PTR_Y:   ptr_lo = `BSLD_PTR_Y_LO;
            PTR_Z:   ptr_lo = `BSLD_PTR_Z_LO;
            default: ptr_lo = `BSLD_PTR_Z_LO;
        endcase
        ptr_val = {wreg_r[ptr_lo + 5'h01], wreg_r[ptr_lo]};
        ptr_nxt = ptr_val;
        ptr_wr  = 1'b0;
        ld_addr = ptr_val;
        if (cmd.op == INDIRECT_LOAD_OP)
        begin
            case (cmd.mode)
                ADDR_POST_INC:
                begin
                    ptr_nxt = ptr_val + 16'h0001;
                    ptr_wr  = 1'b1;
                end
                ADDR_PRE_DEC:
                begin
                    ptr_nxt = ptr_val - 16'h0001;
                    ptr_wr  = 1'b1;
                    ld_addr = ptr_nxt;
                end
                default:
                begin
                    ptr_wr  = 1'b0;
                end
            endcase
        end
        else if (cmd.op == DISPLACED_LOAD_OP)
        begin
            ld_addr = ptr_val + {10'h000, cmd.disp};
        end
    end

    // Single-cycle results and flag updates
    always_comb
    begin
        res       = dst_val;
        res_wr    = 1'b0;
        flags_nxt = flags_r;
        flags_wr  = 1'b0;
        long_op   = 1'b0;
        refused   = 1'b0;
        case (cmd.op)
            IO_BIT_SET_OP, IO_BIT_CLEAR_OP, INDIRECT_LOAD_OP:
            begin
                long_op = 1'b1;
            end
            DISPLACED_LOAD_OP:
            begin
                // X has no displaced form; such a command is dropped without a done pulse
                refused = (cmd.ptr == PTR_X);
                long_op = !refused;
            end
            LOGICAL_LEFT_SHIFT_OP:
            begin
                res = {dst_val[6:0], 1'b0};
                flags_nxt[`BSLD_FLAG_C] = dst_val[7];
            end
            LOGICAL_RIGHT_SHIFT_OP:
            begin
                res = {1'b0, dst_val[7:1]};
                flags_nxt[`BSLD_FLAG_C] = dst_val[0];
            end
            ROTATE_LEFT_CARRY_OP:
            begin
                res = {dst_val[6:0], flags_r[`BSLD_FLAG_C]};
                flags_nxt[`BSLD_FLAG_C] = dst_val[7];
            end
            ROTATE_RIGHT_CARRY_OP:
            begin
                res = {flags_r[`BSLD_FLAG_C], dst_val[7:1]};
                flags_nxt[`BSLD_FLAG_C] = dst_val[0];
            end
            ARITH_RIGHT_SHIFT_OP:
            begin
                res = {dst_val[7], dst_val[7:1]};
                flags_nxt[`BSLD_FLAG_C] = dst_val[0];
            end
            BIT_TO_TRANSFER_FLAG_OP:
            begin
                flags_nxt[`BSLD_FLAG_T] = |(src_val & bit_mask);
                flags_wr = 1'b1;
            end
            TRANSFER_FLAG_TO_BIT_OP:
            begin
                res = flags_r[`BSLD_FLAG_T] ? (dst_val | bit_mask) : (dst_val & ~bit_mask);
                res_wr = 1'b1;
            end
            SIGNED_FLAG_SET_OP, SIGNED_FLAG_CLEAR_OP:
            begin
                flags_nxt[`BSLD_FLAG_S] = (cmd.op == SIGNED_FLAG_SET_OP);
                flags_wr = 1'b1;
            end
            OVERFLOW_FLAG_SET_OP, OVERFLOW_FLAG_CLEAR_OP:
            begin
                flags_nxt[`BSLD_FLAG_V] = (cmd.op == OVERFLOW_FLAG_SET_OP);
                flags_wr = 1'b1;
            end
            HALF_CARRY_SET_OP, HALF_CARRY_CLEAR_OP:
            begin
                flags_nxt[`BSLD_FLAG_H] = (cmd.op == HALF_CARRY_SET_OP);
                flags_wr = 1'b1;
            end
            default:
            begin
                refused = 1'b1;
            end
        endcase
        // Shared Z, N and V for the five shifts; S and H are left alone
        if (cmd.op inside {LOGICAL_LEFT_SHIFT_OP, LOGICAL_RIGHT_SHIFT_OP, ROTATE_LEFT_CARRY_OP,
                           ROTATE_RIGHT_CARRY_OP, ARITH_RIGHT_SHIFT_OP})
        begin
            res_wr = 1'b1;
            flags_wr = 1'b1;
            flags_nxt[`BSLD_FLAG_Z] = (res == 8'h00);
            flags_nxt[`BSLD_FLAG_N] = res[7];
            flags_nxt[`BSLD_FLAG_V] = res[7] ^ flags_nxt[`BSLD_FLAG_C];
        end
    end

    // Sequencer: long operations spend one extra cycle waiting for read data
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r    <= ST_IDLE;
            cmd_busy_r <= 1'b0;
            cmd_done_r <= 1'b0;
        end
        else
        begin
            cmd_done_r <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (accept && long_op)
                    begin
                        state_r    <= ST_WAIT;
                        cmd_busy_r <= 1'b1;
                    end
                    else if (accept && !refused)
                    begin
                        cmd_done_r <= 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    state_r    <= ST_IDLE;
                    cmd_busy_r <= 1'b0;
                    cmd_done_r <= 1'b1;
                end
                default:
                begin
                    state_r    <= ST_IDLE;
                    cmd_busy_r <= 1'b0;
                end
            endcase
        end
    end

    // Pending long-operation context
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_io_r  <= 1'b0;
            pend_set_r <= 1'b0;
            pend_bit_r <= 3'h0;
            pend_dst_r <= 5'h00;
        end
        else if (accept && long_op)
        begin
            pend_io_r  <= (cmd.op == IO_BIT_SET_OP) || (cmd.op == IO_BIT_CLEAR_OP);
            pend_set_r <= (cmd.op == IO_BIT_SET_OP);
            pend_bit_r <= cmd.bit_sel;
            pend_dst_r <= cmd.dst_idx;
        end
    end

    // I/O read-modify-write: read in the first cycle, write back the altered bit in the second
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            io_addr_r  <= '0;
            io_rd_r    <= 1'b0;
            io_wr_r    <= 1'b0;
            io_wdata_r <= 8'h00;
        end
        else
        begin
            io_rd_r <= 1'b0;
            io_wr_r <= 1'b0;
            if (accept && ((cmd.op == IO_BIT_SET_OP) || (cmd.op == IO_BIT_CLEAR_OP)))
            begin
                io_addr_r <= cmd.io_addr[IO_AW-1:0];
                io_rd_r   <= 1'b1;
            end
            if (state_r == ST_WAIT && pend_io_r)
            begin
                io_wr_r <= 1'b1;
                if (pend_set_r)
                begin
                    io_wdata_r <= io_rdata | io_bit_mask;
                end
                else
                begin
                    io_wdata_r <= io_rdata & ~io_bit_mask;
                end
            end
        end
    end

    // Data memory read strobe and address
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dm_addr_r <= '0;
            dm_rd_r   <= 1'b0;
        end
        else
        begin
            dm_rd_r <= 1'b0;
            if (accept && long_op && (cmd.op == INDIRECT_LOAD_OP || cmd.op == DISPLACED_LOAD_OP))
            begin
                dm_addr_r <= ld_addr;
                dm_rd_r   <= 1'b1;
            end
        end
    end

    // Working registers; datapath writes come after software writes so they win
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < `BSLD_NUM_WREGS; i++)
            begin
                wreg_r[i] <= `BSLD_WREG_RST;
            end
        end
        else
        begin
            if (sw_wr && sw_addr < 6'(`BSLD_NUM_WREGS))
            begin
                wreg_r[sw_addr[4:0]] <= sw_wdata;
            end
            if (accept && ptr_wr)
            begin
                wreg_r[ptr_lo]         <= ptr_nxt[7:0];
                wreg_r[ptr_lo + 5'h01] <= ptr_nxt[15:8];
            end
            if (accept && res_wr)
            begin
                wreg_r[cmd.dst_idx] <= res;
            end
            // Loaded byte lands last, so it beats a pointer update to the same register
            if (state_r == ST_WAIT && !pend_io_r)
            begin
                wreg_r[pend_dst_r] <= dm_rdata;
            end
        end
    end

    // Processor flags register; loads and I/O bit operations never touch it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags_r <= `BSLD_FLAGS_RST;
        end
        else if (accept && flags_wr)
        begin
            flags_r <= flags_nxt;
        end
        else if (sw_wr && sw_addr == `BSLD_OFS_FLAGS)
        begin
            flags_r <= sw_wdata;
        end
    end

    // Software read data, valid in the cycle after the read strobe only
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sw_rdata_r <= 8'h00;
        end
        else if (sw_rd && sw_addr < 6'(`BSLD_NUM_WREGS))
        begin
            sw_rdata_r <= wreg_r[sw_addr[4:0]];
        end
        else if (sw_rd && sw_addr == `BSLD_OFS_FLAGS)
        begin
            sw_rdata_r <= flags_r;
        end
        else
        begin
            sw_rdata_r <= 8'h00;  // Unmapped or idle reads as zero
        end
    end

endmodule

// [bench/bsld_datapath_chk.sv]
// Concurrent checks on the ports of the bit/shift/load datapath.
// Assumes one clock domain and the package compiled ahead of this file.
`timescale 1ns/10ps
`include "bsld_regs.svh"

module bsld_datapath_chk
    import bsld_pkg::*;
#(
    parameter int DM_AW = 16,
    parameter int IO_AW = 5
)
(
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic             cmd_valid,
    input wire bsld_cmd_t        cmd,
    input wire logic             cmd_busy_r,
    input wire logic             cmd_done_r,
    input wire logic [IO_AW-1:0] io_addr_r,
    input wire logic             io_rd_r,
    input wire logic             io_wr_r,
    input wire logic [7:0]       io_wdata_r,
    input wire logic [7:0]       io_rdata,
    input wire logic             dm_rd_r,
    input wire logic [7:0]       flags_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // A command counts only when the sequencer is free to take it
    logic take;
    assign take = cmd_valid && !cmd_busy_r;

    short_done_a: assert property (take && cmd.op inside {[LOGICAL_LEFT_SHIFT_OP:HALF_CARRY_CLEAR_OP]}
        |=> cmd_done_r && !cmd_busy_r) else $error("short op did not finish in one cycle");
    io_seq_a: assert property (take && cmd.op inside {IO_BIT_SET_OP, IO_BIT_CLEAR_OP}
        |=> cmd_busy_r && io_rd_r && io_addr_r == $past(cmd.io_addr)
        ##1 io_wr_r && cmd_done_r && !cmd_busy_r) else $error("io bit op sequence wrong");
    io_set_a: assert property (take && cmd.op == IO_BIT_SET_OP |=> ##1 flags_r == $past(flags_r, 2)
        && io_wdata_r == ($past(io_rdata) | (8'h01 << $past(cmd.bit_sel, 2)))) else $error("io set data wrong");
    io_clear_a: assert property (take && cmd.op == IO_BIT_CLEAR_OP |=> ##1 flags_r == $past(flags_r, 2)
        && io_wdata_r == ($past(io_rdata) & ~(8'h01 << $past(cmd.bit_sel, 2)))) else $error("io clear data wrong");
    shift_flags_a: assert property (take && cmd.op inside {[LOGICAL_LEFT_SHIFT_OP:ARITH_RIGHT_SHIFT_OP]}
        |=> flags_r[`BSLD_FLAG_V] == (flags_r[`BSLD_FLAG_N] ^ flags_r[`BSLD_FLAG_C])
        && flags_r[7:4] == $past(flags_r[7:4])) else $error("shift flags wrong");
    lsr_neg_a: assert property (take && cmd.op == LOGICAL_RIGHT_SHIFT_OP |=> !flags_r[`BSLD_FLAG_N])
        else $error("right shift left N set");
    bst_only_a: assert property (take && cmd.op == BIT_TO_TRANSFER_FLAG_OP
        |=> (flags_r & 8'hBF) == ($past(flags_r) & 8'hBF)) else $error("bit store touched flags");
    bld_flags_a: assert property (take && cmd.op == TRANSFER_FLAG_TO_BIT_OP |=> $stable(flags_r))
        else $error("bit load touched flags");
    sflag_set_a: assert property (take && cmd.op == SIGNED_FLAG_SET_OP |=> flags_r == ($past(flags_r) | 8'h10))
        else $error("signed flag set wrong");
    vflag_clear_a: assert property (take && cmd.op == OVERFLOW_FLAG_CLEAR_OP |=> flags_r == ($past(flags_r) & 8'hF7))
        else $error("overflow clear wrong");
    hflag_set_a: assert property (take && cmd.op == HALF_CARRY_SET_OP |=> flags_r == ($past(flags_r) | 8'h20))
        else $error("half carry set wrong");
    load_seq_a: assert property (take && cmd.op == INDIRECT_LOAD_OP |=> dm_rd_r && cmd_busy_r && $stable(flags_r)
        ##1 cmd_done_r && $stable(flags_r)) else $error("load sequence wrong");

    // Main scenarios reached
    cover property (io_wr_r && cmd_done_r);
    cover property (dm_rd_r ##1 cmd_done_r);
    cover property (take && cmd.op == ROTATE_RIGHT_CARRY_OP);
endmodule

bind bsld_datapath bsld_datapath_chk #(.DM_AW(DM_AW), .IO_AW(IO_AW)) u_bsld_datapath_chk (.clk, .reset_n,
    .cmd_valid, .cmd, .cmd_busy_r, .cmd_done_r, .io_addr_r, .io_rd_r, .io_wr_r, .io_wdata_r, .io_rdata,
    .dm_rd_r, .flags_r);

// [bench/tb.sv]
// Self-checking bench for the bit/shift/load datapath, driving commands and the software port.
// Assumes the I/O space and memory answer only in the cycle in which their read strobe is high.
`timescale 1ns/10ps

module tb;
    import bsld_pkg::*;
    localparam logic [7:0] IO_VAL = 8'hA5;
    localparam logic [7:0] DM_VAL = 8'h5A;
    logic        clk, reset_n, cmd_valid, sw_wr, sw_rd;
    logic        cmd_busy_r, cmd_done_r, io_rd_r, io_wr_r, dm_rd_r;
    bsld_cmd_t   cmd;
    logic [4:0]  io_addr_r;
    logic [5:0]  sw_addr;
    logic [7:0]  sw_wdata, sw_rdata_r, flags_r, io_wdata_r, io_rdata, dm_rdata;
    logic [15:0] dm_addr_r, dm_seen, io_seen;
    int          err_total, checks;

    bsld_datapath u_bsld_datapath (.clk, .reset_n, .cmd_valid, .cmd, .cmd_busy_r, .cmd_done_r, .io_addr_r,
        .io_rd_r, .io_wr_r, .io_wdata_r, .io_rdata, .dm_addr_r, .dm_rd_r, .dm_rdata, .sw_addr, .sw_wdata,
        .sw_wr, .sw_rd, .sw_rdata_r, .flags_r);

    // Read data is only good while the strobe stands; otherwise the inverse, so a late sample is caught
    assign io_rdata = io_rd_r ? IO_VAL : ~IO_VAL;
    assign dm_rdata = dm_rd_r ? DM_VAL : ~DM_VAL;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("counts: %0d checks, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic sw_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 check({8'h00, sw_rdata_r}, {8'h00, exp});
    endtask

    // Issue one command and measure cycles to done; lat 0 means no done may come
    task automatic issue(input bsld_cmd_t c, input logic [15:0] lat);
        logic [15:0] n;
        n = 16'h0;
        dm_seen = 'x;  // Stale values from an earlier command must not pass
        io_seen = 'x;
        @(posedge clk);
        cmd <= c;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (int i = 1; i <= 4; i++)
        begin
            #1;
            if (dm_rd_r === 1'b1) dm_seen = dm_addr_r;
            if (io_wr_r === 1'b1) io_seen = {8'h00, io_wdata_r};
            if (cmd_done_r === 1'b1 && n == 16'h0) n = 16'(i);
            @(posedge clk);
        end
        check(n, lat);
    endtask

    function automatic bsld_cmd_t mk(bsld_op_t op, logic [4:0] dst, logic [4:0] src, logic [2:0] b,
                                     logic [4:0] io, bsld_ptr_t p, bsld_mode_t m, logic [5:0] d);
        return '{op, dst, src, b, io, p, m, d};
    endfunction

    // Result and flags of a shift worked out bit by bit
    function automatic logic [15:0] shift_exp(bsld_op_t op, logic [7:0] v, logic [7:0] f);
        logic [7:0] r;
        logic       c;
        case (op)
            LOGICAL_LEFT_SHIFT_OP:  begin r = {v[6:0], 1'b0}; c = v[7]; end
            LOGICAL_RIGHT_SHIFT_OP: begin r = {1'b0, v[7:1]}; c = v[0]; end
            ROTATE_LEFT_CARRY_OP:   begin r = {v[6:0], f[0]}; c = v[7]; end
            ROTATE_RIGHT_CARRY_OP:  begin r = {f[0], v[7:1]}; c = v[0]; end
            default:                begin r = {v[7], v[7:1]}; c = v[0]; end
        endcase
        f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        return {f, r};
    endfunction

    initial
    begin
        bsld_op_t    sh[5] = '{LOGICAL_LEFT_SHIFT_OP, LOGICAL_RIGHT_SHIFT_OP, ROTATE_LEFT_CARRY_OP,
                               ROTATE_RIGHT_CARRY_OP, ARITH_RIGHT_SHIFT_OP};
        logic [7:0]  sv[5] = '{8'h81, 8'h01, 8'h80, 8'h01, 8'h81};
        bsld_op_t    fo[6] = '{SIGNED_FLAG_SET_OP, SIGNED_FLAG_CLEAR_OP, OVERFLOW_FLAG_SET_OP,
                               OVERFLOW_FLAG_CLEAR_OP, HALF_CARRY_SET_OP, HALF_CARRY_CLEAR_OP};
        int          fb[6] = '{4, 4, 3, 3, 5, 5};
        logic [7:0]  f0;
        logic [15:0] ex;
        {reset_n, cmd_valid, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
        cmd = '0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values and an unmapped address
        sw_read(6'h05, 8'h00);
        sw_read(6'h3F, 8'h00);
        sw_read(6'h20, 8'h00);
        $display("test reset done");
        // Every shift, carry in set for the rotates
        for (int i = 0; i < 5; i++)
        begin
            f0 = (i inside {2, 3}) ? 8'h61 : 8'h60;
            ex = shift_exp(sh[i], sv[i], f0);
            sw_write(6'h10, sv[i]);
            sw_write(6'h3F, f0);
            issue(mk(sh[i], 5'h10, 5'h00, 3'h0, 5'h00, PTR_X, ADDR_PLAIN, 6'h00), 16'h1);
            sw_read(6'h10, ex[7:0]);
            sw_read(6'h3F, ex[15:8]);
        end
        $display("test shifts done");
        // Single flag set and clear from the opposite state
        for (int i = 0; i < 6; i++)
        begin
            f0 = (i % 2 == 0) ? 8'h00 : 8'hFF;
            sw_write(6'h3F, f0);
            issue(mk(fo[i], 5'h00, 5'h00, 3'h0, 5'h00, PTR_X, ADDR_PLAIN, 6'h00), 16'h1);
            sw_read(6'h3F, f0 ^ (8'h01 << fb[i]));
        end
        // Bit store into the transfer flag, then bit load out of it
        sw_write(6'h03, 8'h04);
        sw_write(6'h3F, 8'h00);
        issue(mk(BIT_TO_TRANSFER_FLAG_OP, 5'h00, 5'h03, 3'h2, 5'h00, PTR_X, ADDR_PLAIN, 6'h00), 16'h1);
        sw_read(6'h3F, 8'h40);
        issue(mk(TRANSFER_FLAG_TO_BIT_OP, 5'h04, 5'h00, 3'h7, 5'h00, PTR_X, ADDR_PLAIN, 6'h00), 16'h1);
        sw_read(6'h04, 8'h80);
        sw_read(6'h3F, 8'h40);
        $display("test flags done");
        // I/O bit set and clear as read-modify-write
        issue(mk(IO_BIT_SET_OP, 5'h00, 5'h00, 3'h1, 5'h0C, PTR_X, ADDR_PLAIN, 6'h00), 16'h2);
        check(io_seen, 16'h00A7);
        check({11'h0, io_addr_r}, 16'h000C);
        issue(mk(IO_BIT_CLEAR_OP, 5'h00, 5'h00, 3'h0, 5'h1F, PTR_X, ADDR_PLAIN, 6'h00), 16'h2);
        check(io_seen, 16'h00A4);
        sw_read(6'h3F, 8'h40);
        $display("test io done");
        // Post-increment wrapping from the top of the pointer range
        sw_write(6'h1A, 8'hFF);
        sw_write(6'h1B, 8'hFF);
        issue(mk(INDIRECT_LOAD_OP, 5'h02, 5'h00, 3'h0, 5'h00, PTR_X, ADDR_POST_INC, 6'h00), 16'h2);
        check(dm_seen, 16'hFFFF);
        sw_read(6'h02, DM_VAL);
        sw_read(6'h1A, 8'h00);
        sw_read(6'h1B, 8'h00);
        // Pre-decrement wrapping from zero
        issue(mk(INDIRECT_LOAD_OP, 5'h03, 5'h00, 3'h0, 5'h00, PTR_Z, ADDR_PRE_DEC, 6'h00), 16'h2);
        check(dm_seen, 16'hFFFF);
        sw_read(6'h03, DM_VAL);
        sw_read(6'h1E, 8'hFF);
        sw_read(6'h1F, 8'hFF);
        // Largest displacement, pointer left alone; X is not allowed a displacement
        sw_write(6'h1C, 8'h34);
        sw_write(6'h1D, 8'h12);
        issue(mk(DISPLACED_LOAD_OP, 5'h05, 5'h00, 3'h0, 5'h00, PTR_Y, ADDR_PLAIN, 6'h3F), 16'h2);
        check(dm_seen, 16'h1273);
        sw_read(6'h1C, 8'h34);
        sw_read(6'h05, DM_VAL);
        issue(mk(DISPLACED_LOAD_OP, 5'h06, 5'h00, 3'h0, 5'h00, PTR_X, ADDR_PLAIN, 6'h01), 16'h0);
        sw_read(6'h06, 8'h00);
        // Plain indirect load through Y, pointer left alone
        issue(mk(INDIRECT_LOAD_OP, 5'h07, 5'h00, 3'h0, 5'h00, PTR_Y, ADDR_PLAIN, 6'h00), 16'h2);
        check(dm_seen, 16'h1234);
        sw_read(6'h07, DM_VAL);
        sw_read(6'h1D, 8'h12);
        $display("test loads done");
        finish_test();
    end

    // Hang guard
    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule
